// >>> tcm_pkg.sv
// Package of constants and types for the timer/counter multiplexer.
package tcm_pkg;
  // ----------------------------------------------------------------
  // Sizes and encodings
  // ----------------------------------------------------------------
  localparam int          TCM_NUM_OBJ    = 4;
  localparam int          TCM_OBJ_W      = 2;
  localparam int          TCM_CLK_W      = 4;
  localparam int          TCM_VAL_W      = 16;
  localparam int          TCM_IO_W       = 8;
  localparam logic [15:0] TCM_OVERRANGE  = 16'hffff;
  localparam logic [3:0]  TCM_SEL_CLK_MAX = 4'h7;
  localparam logic [1:0]  TCM_RST_OWNER  = 2'h3;
  localparam logic [3:0]  TCM_RST_DIV    = 4'h0;
  // ----------------------------------------------------------------
  // Output timing of serial and parallel writes
  // ----------------------------------------------------------------
  // The window is given at a 40 MHz reference clock and is fixed in cycles.
  localparam int REF_MHZ          = 40;
  localparam int OUT_MIN_NS       = 12500;
  localparam int OUT_MAX_NS       = 25000;
  localparam int OUT_NOM_NS       = (OUT_MIN_NS + OUT_MAX_NS) / 2;
  localparam int OUT_DELAY_CYC    = (OUT_NOM_NS * REF_MHZ) / 1000;
  localparam int OUT_MIN_CYC      = (OUT_MIN_NS * REF_MHZ + 999) / 1000;
  localparam int OUT_MAX_CYC      = (OUT_MAX_NS * REF_MHZ) / 1000;
  // ----------------------------------------------------------------
  // Measurement state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCM_DISCARD = 2'b00,
    TCM_PRIMED  = 2'b01,
    TCM_RUNNING = 2'b11
  } tcm_meas_t;
endpackage

// >>> tcm_meas.sv
// Shared measurement circuit: counts clock-selector ticks between falling edges.
`timescale 1ns/1ps
`default_nettype none
module tcm_meas
  import tcm_pkg::*;
#(
  parameter int VAL_W = TCM_VAL_W,
  parameter int CLK_W = TCM_CLK_W
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // Control
  input  wire logic             restart,
  input  wire logic [CLK_W-1:0] clk_sel,
  input  wire logic             sig_in,
  // Result
  output logic                  done,
  output logic [VAL_W-1:0]      value
);
  initial begin
    if (VAL_W < 2 || CLK_W > 5) $error("tcm_meas: unsupported widths");
  end

  logic [31:0]      pre_q;
  logic [VAL_W-1:0] cnt_q;
  logic             sig_q;
  logic             tick;

  // A tick every 2^clk_sel cycles sets measurement resolution.
  assign tick = ((pre_q & ((32'h1 << clk_sel) - 32'h1)) == 32'h0);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= 32'h0;
      cnt_q <= '0;
      sig_q <= 1'b0;
      done  <= 1'b0;
      value <= '0;
    end else begin
      pre_q <= pre_q + 32'h1;
      sig_q <= sig_in;
      done  <= 1'b0;
      if (restart) begin
        cnt_q <= '0;
        pre_q <= 32'h0;
      end else if (sig_q && !sig_in) begin
        value <= cnt_q;
        done  <= 1'b1;
        cnt_q <= '0;
      end else if (tick && cnt_q != {VAL_W{1'b1}}) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tcm_mux.sv
// Timer/counter multiplexer with per-object clock selectors and direct I/O sampling.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - After reset the last configured object owns the circuit.
// - A select command moves ownership to the named object.
// - Select may carry clock 0..7; otherwise the configured default loads.
// - Set-clock takes a mandatory selector 0..15 for any object.
// - Set-clock updates an object's selector even when not owner.
// - A select-supplied selector stays until explicitly rewritten.
// - Select without a selector restores the configured default.
// - Reads of unselected objects return 65535, no flag, no event.
// - First measurement after select or reset is discarded.
// - Preserve before the first measurement completes keeps that first measurement.
// - Update event appears on the first owner read after each kept measurement.
// - Direct inputs sample on read or event evaluation.
// - Serial and parallel inputs sample when the read is requested.
// - Serial and parallel outputs change 12.5 to 25 us after write at the 40 MHz reference clock.
// - A latched value repeats on reads until a newer one latches.
module tcm_mux
  import tcm_pkg::*;
#(
  parameter int NUM_OBJ = TCM_NUM_OBJ,
  parameter int OBJ_W   = TCM_OBJ_W,
  parameter int IO_W    = TCM_IO_W
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  // Configured defaults
  input  wire logic [NUM_OBJ*4-1:0] def_clk,
  // Commands
  input  wire logic                 sel_cmd,
  input  wire logic [OBJ_W-1:0]     sel_obj,
  input  wire logic                 sel_has_clk,
  input  wire logic [2:0]           sel_clk,
  input  wire logic                 setclk_cmd,
  input  wire logic [OBJ_W-1:0]     setclk_obj,
  input  wire logic [3:0]           setclk_val,
  input  wire logic                 preserve_cmd,
  input  wire logic                 rd_cmd,
  input  wire logic [OBJ_W-1:0]     rd_obj,
  input  wire logic                 evt_eval,
  // Multiplexed pins
  input  wire logic [NUM_OBJ-1:0]   tc_pin,
  // Direct, serial and parallel pins
  input  wire logic [IO_W-1:0]      io_pin_in,
  input  wire logic                 io_wr_cmd,
  input  wire logic [IO_W-1:0]      io_wr_data,
  // Results
  output logic [TCM_VAL_W-1:0]      rd_value,
  output logic                      rd_valid,
  output logic                      new_value_flag,
  output logic                      update_event,
  output logic [OBJ_W-1:0]          owner,
  output logic [NUM_OBJ*4-1:0]      clk_sel_all,
  output logic [IO_W-1:0]           io_sample,
  output logic [IO_W-1:0]           io_pin_out
);
  initial begin
    if (NUM_OBJ != (1 << OBJ_W)) $error("tcm_mux: NUM_OBJ must be 2^OBJ_W");
    if (int'(TCM_RST_OWNER) != NUM_OBJ - 1) $error("tcm_mux: reset owner must be the last");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [NUM_OBJ-1:0] tc_s1_q, tc_s2_q;
  logic [IO_W-1:0]    io_s1_q, io_s2_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tc_s1_q <= '0;
      tc_s2_q <= '0;
      io_s1_q <= '0;
      io_s2_q <= '0;
    end else begin
      tc_s1_q <= tc_pin;
      tc_s2_q <= tc_s1_q;
      io_s1_q <= io_pin_in;
      io_s2_q <= io_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Ownership and clock selectors
  // ----------------------------------------------------------------
  logic [3:0] clk_q [NUM_OBJ];
  logic       loaded_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      owner <= OBJ_W'(TCM_RST_OWNER);
    end else if (sel_cmd) begin
      owner <= sel_obj;
    end
  end

  // Defaults are loaded one cycle after release so no port reaches reset.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_OBJ; g++) begin : g_clk
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          clk_q[g] <= TCM_RST_DIV;
        end else if (!loaded_q) begin
          clk_q[g] <= def_clk[g*4 +: 4];
        end else if (setclk_cmd && setclk_obj == OBJ_W'(g)) begin
          clk_q[g] <= setclk_val;
        end else if (sel_cmd && sel_obj == OBJ_W'(g)) begin
          clk_q[g] <= sel_has_clk ? {1'b0, sel_clk} : def_clk[g*4 +: 4];
        end
      end
      assign clk_sel_all[g*4 +: 4] = clk_q[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Shared measurement circuit
  // ----------------------------------------------------------------
  logic                 meas_done;
  logic [TCM_VAL_W-1:0] meas_val;
  tcm_meas #(.VAL_W(TCM_VAL_W), .CLK_W(TCM_CLK_W)) u_meas (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .restart (sel_cmd | ~loaded_q),
    .clk_sel (clk_q[owner]),
    .sig_in  (tc_s2_q[owner]),
    .done    (meas_done),
    .value   (meas_val)
  );

  // ----------------------------------------------------------------
  // Discard of the first measurement
  // ----------------------------------------------------------------
  tcm_meas_t            st_q;
  logic                 fresh_q;
  logic [TCM_VAL_W-1:0] latch_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= TCM_DISCARD;
    end else if (sel_cmd) begin
      st_q <= TCM_DISCARD;
    end else begin
      case (st_q)
        TCM_DISCARD: begin
          if (preserve_cmd) st_q <= TCM_PRIMED;
          else if (meas_done) st_q <= TCM_RUNNING;
        end
        TCM_PRIMED: begin
          if (meas_done) st_q <= TCM_RUNNING;
        end
        default: st_q <= TCM_RUNNING;
      endcase
    end
  end

  // A new result wins over the read that consumes the fresh mark.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      latch_q <= '0;
      fresh_q <= 1'b0;
    end else if (sel_cmd) begin
      fresh_q <= 1'b0;
    end else if (meas_done && st_q != TCM_DISCARD) begin
      latch_q <= meas_val;
      fresh_q <= 1'b1;
    end else if (rd_cmd && rd_obj == owner) begin
      fresh_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read answers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_value       <= '0;
      rd_valid       <= 1'b0;
      new_value_flag <= 1'b0;
      update_event   <= 1'b0;
    end else begin
      rd_valid     <= rd_cmd;
      update_event <= 1'b0;
      if (rd_cmd) begin
        if (rd_obj != owner) begin
          rd_value       <= TCM_OVERRANGE;
          new_value_flag <= 1'b0;
        end else begin
          rd_value       <= latch_q;
          new_value_flag <= fresh_q;
          update_event   <= fresh_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Direct, serial and parallel pins
  // ----------------------------------------------------------------
  logic [15:0]     wr_cnt_q;
  logic            wr_busy_q;
  logic [IO_W-1:0] wr_data_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      io_sample <= '0;
    end else if (rd_cmd || evt_eval) begin
      io_sample <= io_s2_q;
    end
  end

  // The delay is a fixed cycle count, midway through the window at the reference
  // clock, so in time it shrinks as the clock gets faster.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_cnt_q   <= '0;
      wr_busy_q  <= 1'b0;
      wr_data_q  <= '0;
      io_pin_out <= '0;
    end else if (io_wr_cmd) begin
      wr_cnt_q  <= 16'(OUT_DELAY_CYC - 1);
      wr_busy_q <= 1'b1;
      wr_data_q <= io_wr_data;
    end else if (wr_busy_q) begin
      if (wr_cnt_q == 16'h0) begin
        io_pin_out <= wr_data_q;
        wr_busy_q  <= 1'b0;
      end else begin
        wr_cnt_q <= wr_cnt_q - 16'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_sel_owner: assert property (sel_cmd |=> owner == $past(sel_obj))
    else $error("owner did not follow select");
  a_unsel_over: assert property (rd_cmd && rd_obj != owner |=>
      rd_value == 16'hffff && !new_value_flag && !update_event)
    else $error("unselected read not overrange");
  a_discard_first: assert property (st_q == TCM_DISCARD && meas_done && !sel_cmd |=>
      !fresh_q)
    else $error("first measurement not discarded");
  a_preserve_keep: assert property (st_q == TCM_PRIMED && meas_done && !sel_cmd |=>
      fresh_q)
    else $error("preserved measurement lost");
  a_event_fresh: assert property (update_event |-> $past(fresh_q))
    else $error("update without fresh value");
  a_setclk_any: assert property (setclk_cmd && loaded_q |=>
      clk_q[$past(setclk_obj)] == $past(setclk_val))
    else $error("set-clock not applied");
  a_sel_default: assert property (sel_cmd && !sel_has_clk && !setclk_cmd && loaded_q |=>
      clk_q[$past(sel_obj)] == $past(def_clk[sel_obj*4 +: 4]))
    else $error("default clock not restored");
  a_out_delay: assert property (io_wr_cmd ##1 (!io_wr_cmd)[*8] |-> io_pin_out == $past(io_pin_out, 8))
    else $error("output changed too early");
  a_latch_hold: assert property (!meas_done && !sel_cmd |=> $stable(latch_q))
    else $error("latched value moved");

  c_select: cover property (sel_cmd ##[1:200] update_event);
  c_preserve: cover property (preserve_cmd ##[1:200] update_event);
  c_overrange: cover property (rd_cmd && rd_obj != owner);
  c_write: cover property (io_wr_cmd ##1 !io_wr_cmd [*8]);
endmodule
`default_nettype wire

// >>> tcm_far_pins.sv
// Model of the external signals that drive the multiplexed timer/counter pins.
`timescale 1ns/1ps
`default_nettype none
module tcm_far_pins
  import tcm_pkg::*;
(
  // Clock
  input  wire logic               clk_sys,
  // Pins
  output var  logic [TCM_NUM_OBJ-1:0] tc_pin
);
  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Idle pins sit high, as with a pull-up, so only commanded edges occur.
  initial begin
    tc_pin = '1;
  end

  // One falling edge on pin i, released after four cycles.
  task automatic fall(input int i);
    @(posedge clk_sys);
    #1 tc_pin[i] = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 tc_pin[i] = 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> tcm_mux_bench.sv
// Self-checking testbench for the timer/counter multiplexer.
`timescale 1ns/1ps
`default_nettype none
module tcm_mux_bench;
  import tcm_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk_sys;
  logic        reset_n;
  logic [15:0] def_clk;
  logic        sel_cmd, sel_has_clk, setclk_cmd, preserve_cmd, rd_cmd, evt_eval, io_wr_cmd;
  logic [1:0]  sel_obj, setclk_obj, rd_obj;
  logic [2:0]  sel_clk;
  logic [3:0]  setclk_val;
  logic [3:0]  tc_pin;
  logic [7:0]  io_pin_in, io_wr_data, io_sample, io_pin_out;
  logic [15:0] rd_value, clk_sel_all;
  logic        rd_valid, new_value_flag, update_event;
  logic [1:0]  owner;
  int          bad_count;
  int          n_checks;
  int          n;

  tcm_mux u_tcm_mux (.clk_sys(clk_sys), .reset_n(reset_n), .def_clk(def_clk),
    .sel_cmd(sel_cmd), .sel_obj(sel_obj), .sel_has_clk(sel_has_clk), .sel_clk(sel_clk),
    .setclk_cmd(setclk_cmd), .setclk_obj(setclk_obj), .setclk_val(setclk_val),
    .preserve_cmd(preserve_cmd), .rd_cmd(rd_cmd), .rd_obj(rd_obj), .evt_eval(evt_eval),
    .tc_pin(tc_pin), .io_pin_in(io_pin_in), .io_wr_cmd(io_wr_cmd), .io_wr_data(io_wr_data),
    .rd_value(rd_value), .rd_valid(rd_valid), .new_value_flag(new_value_flag),
    .update_event(update_event), .owner(owner), .clk_sel_all(clk_sel_all),
    .io_sample(io_sample), .io_pin_out(io_pin_out));
  tcm_far_pins u_tcm_far_pins (.clk_sys(clk_sys), .tc_pin(tc_pin));

  // ----------------------------------------------------------------
  // Clock and tasks
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic do_sel(input logic [1:0] obj, input logic hc, input logic [2:0] c);
    sel_obj = obj;
    sel_has_clk = hc;
    sel_clk = c;
    sel_cmd = 1'b1;
    cyc(1);
    sel_cmd = 1'b0;
  endtask

  task automatic do_setclk(input logic [1:0] obj, input logic [3:0] v);
    setclk_obj = obj;
    setclk_val = v;
    setclk_cmd = 1'b1;
    cyc(1);
    setclk_cmd = 1'b0;
  endtask

  // Read pulse; outputs are checked in the cycle where rd_valid stands.
  task automatic do_rd(input logic [1:0] obj);
    rd_obj = obj;
    rd_cmd = 1'b1;
    cyc(1);
    rd_cmd = 1'b0;
  endtask

  task automatic do_reset();
    reset_n = 1'b0;
    cyc(6);
    reset_n = 1'b1;
    cyc(2);
  endtask

  // Cuts a hang short; counts as a mismatch.
  initial begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    bad_count = 0;
    n_checks = 0;
    def_clk = 16'h2613;
    {sel_cmd, sel_has_clk, setclk_cmd, preserve_cmd, rd_cmd, evt_eval, io_wr_cmd} = '0;
    {sel_obj, setclk_obj, rd_obj, sel_clk, setclk_val} = '0;
    io_pin_in = 8'h00;
    io_wr_data = 8'h00;
    do_reset();
    chk({14'h0, owner}, 16'h0003);
    chk(clk_sel_all, 16'h2613);
    do_sel(2'h1, 1'b1, 3'h5);
    chk({14'h0, owner}, 16'h0001);
    chk({12'h0, clk_sel_all[7:4]}, 16'h0005);
    do_setclk(2'h2, 4'hf);
    chk({12'h0, clk_sel_all[11:8]}, 16'h000f);
    chk({12'h0, clk_sel_all[7:4]}, 16'h0005);
    do_sel(2'h1, 1'b0, 3'h0);
    chk({12'h0, clk_sel_all[7:4]}, 16'h0001);
    cyc(1);
    do_sel(2'h1, 1'b1, 3'h0);
    // Edges on a non-owner pin must not be measured.
    u_tcm_far_pins.fall(3);
    cyc(8);
    do_rd(2'h3);
    chk(rd_value, TCM_OVERRANGE);
    chk({14'h0, new_value_flag, update_event}, 16'h0000);
    // First edge after selection is discarded, the second one reported.
    u_tcm_far_pins.fall(1);
    cyc(8);
    do_rd(2'h1);
    chk({14'h0, new_value_flag, update_event}, 16'h0000);
    cyc(27);
    u_tcm_far_pins.fall(1);
    cyc(8);
    do_rd(2'h1);
    chk({13'h0, rd_valid, new_value_flag, update_event}, 16'h0007);
    chk({15'h0, rd_value >= 16'd39 && rd_value <= 16'd41}, 16'h0001);
    n = rd_value;
    cyc(3);
    do_rd(2'h1);
    chk(rd_value, n[15:0]);
    chk({14'h0, new_value_flag, update_event}, 16'h0000);
    // Preserve keeps the first measurement after a new selection.
    do_sel(2'h2, 1'b0, 3'h0);
    chk({12'h0, clk_sel_all[11:8]}, 16'h0006);
    preserve_cmd = 1'b1;
    cyc(1);
    preserve_cmd = 1'b0;
    u_tcm_far_pins.fall(2);
    cyc(8);
    do_rd(2'h2);
    chk({15'h0, new_value_flag}, 16'h0001);
    cyc(1);
    do_rd(2'h1);
    chk(rd_value, TCM_OVERRANGE);
    chk({14'h0, new_value_flag, update_event}, 16'h0000);
    // Direct input sampling on read and on event evaluation.
    io_pin_in = 8'ha5;
    cyc(4);
    do_rd(2'h0);
    cyc(1);
    chk({8'h0, io_sample}, 16'h00a5);
    io_pin_in = 8'h5a;
    cyc(4);
    chk({8'h0, io_sample}, 16'h00a5);
    evt_eval = 1'b1;
    cyc(1);
    evt_eval = 1'b0;
    cyc(1);
    chk({8'h0, io_sample}, 16'h005a);
    // Output delay after a write lies within the window counted in reference-clock cycles.
    io_wr_data = 8'h3c;
    io_wr_cmd = 1'b1;
    cyc(1);
    io_wr_cmd = 1'b0;
    n = 1;
    while (io_pin_out !== 8'h3c && n < OUT_MAX_CYC + 4) begin
      cyc(1);
      n++;
    end
    chk({15'h0, n >= OUT_MIN_CYC - 1 && n <= OUT_MAX_CYC + 2}, 16'h0001);
    // A reset in mid-run returns ownership and discards the first edge.
    do_reset();
    chk({14'h0, owner}, 16'h0003);
    u_tcm_far_pins.fall(3);
    cyc(8);
    do_rd(2'h3);
    chk({14'h0, new_value_flag, update_event}, 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
